// file: hw/i2c_master_status_flags.sv
// Purpose: status flags, control enables and interrupt of an i2c master
// Assumes: engine strobes are on pclk; scl/sda arrive from pads
// Notes:   shift engine and fifos live outside and report by strobes
//
// Added by the designer: the APB register port.
`timescale 1ns/1ns
`include "i2c_status_defines.svh"

// Summary of operation
// - status is a 16-bit read-only word, all zero after reset
// - any start condition on the bus sets bus busy, bit 10
// - a stop condition on the bus clears bus busy
// - bit 9 sets when a byte is pushed into a full rx fifo
// - bit 8 sets once a master transfer with its slave finishes
// - transfer complete with its enable set raises the interrupt
// - software may clear transfer complete though the word is read-only
// - bit 7 sets on data nack, interrupts when nack enable is set
// - bit 6 is high while the master processes a transaction
// - bit 6 is low when idle or another master owns the bus
// - bit 5 sets on lost arbitration, interrupts when enabled
// - bit 4 sets on address nack, interrupts when nack enable is set
// - bit 3 sets when data enters the rx fifo, interrupts when enabled
// - bit 2 high after address+write with tx fifo at most one byte
// - bits 1:0 give tx fifo level: empty, one, two, full
// - control enables: complete 8, nack 7, arb 6, tx 5, rx 4
module i2c_master_status_flags (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic pclken,
  // apb slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // i2c lines as seen at the pads
  input wire logic scl_pin,
  input wire logic sda_pin,
  // reports from the shift engine
  input wire logic master_busy,
  input wire logic master_start,
  input wire logic addr_write_sent,
  input wire logic xfer_done_evt,
  input wire logic addr_nack_evt,
  input wire logic data_nack_evt,
  input wire logic arb_lost_evt,
  // reports from the fifos
  input wire logic rx_push,
  input wire logic rx_pop,
  input wire logic rx_fifo_full,
  input wire logic rx_fifo_empty,
  input wire logic [1:0] tx_count,
  input wire logic tx_fifo_full,
  // control bits for the engine and the interrupt
  output i2c_status_pkg::reg16_t master_control,
  output logic irq
);
  import i2c_status_pkg::*;

  // ----------------------------------------------------------------
  // sub-blocks
  // ----------------------------------------------------------------
  line_event_if lev ();
  reg_access_if ra ();

  // start and stop come from the pads through a synchroniser
  i2c_line_watch u_line_watch (
    .pclk(pclk),
    .presetn(presetn),
    .pclken(pclken),
    .scl_pin(scl_pin),
    .sda_pin(sda_pin),
    .ev(lev.src)
  );

  // register bus front end
  apb_reg_port u_apb (
    .pclk(pclk),
    .presetn(presetn),
    .pclken(pclken),
    .psel(psel),
    .penable(penable),
    .pwrite(pwrite),
    .paddr(paddr),
    .pwdata(pwdata),
    .prdata(prdata),
    .pready(pready),
    .pslverr(pslverr),
    .ra(ra.port)
  );

  // ----------------------------------------------------------------
  // register state
  // ----------------------------------------------------------------
  reg16_t control_reg;
  bus_state_e bus_state_reg;
  bus_state_e bus_state_next;
  logic rx_ovf_reg;
  logic xfer_done_reg;
  logic data_nack_reg;
  logic master_act_reg;
  logic arb_lost_reg;
  logic addr_nack_reg;
  logic rx_req_reg;
  logic tx_req_reg;
  logic [1:0] tx_lvl_reg;
  logic [1:0] tx_lvl_next;
  logic ctrl_wr;
  logic stat_wr;
  logic done_clr;
  reg16_t status_word;

  // write strobes per register
  assign ctrl_wr = ra.wr_stb && addr_is(ra.addr, `CTRL_ADDR);
  assign stat_wr = ra.wr_stb && addr_is(ra.addr, `STAT_ADDR);

  // ----------------------------------------------------------------
  // control register
  // ----------------------------------------------------------------
  // enable positions
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      control_reg <= `CTRL_RESET;
    end else if (pclken && ctrl_wr) begin
      control_reg <= ra.wdata & `CTRL_WR_MASK;
    end
  end

  assign master_control = control_reg;

  // ----------------------------------------------------------------
  // bus ownership tracker
  // ----------------------------------------------------------------
  // next state from line conditions, start checked when free, stop only when held
  always_comb begin
    bus_state_next = bus_state_reg;
    case (bus_state_reg)
      BUS_FREE: begin
        if (lev.start_det) bus_state_next = BUS_HELD;
      end
      BUS_HELD: begin
        if (lev.stop_det) bus_state_next = BUS_FREE;
      end
      default: begin
        bus_state_next = BUS_FREE;
      end
    endcase
  end

  // repeated starts keep the bus held, so no exit on start
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      bus_state_reg <= BUS_FREE;
    end else if (pclken) begin
      bus_state_reg <= bus_state_next;
    end
  end

  // ----------------------------------------------------------------
  // receive fifo flags
  // ----------------------------------------------------------------
  // overflow on full push
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rx_ovf_reg <= 1'b0;
    end else if (pclken) begin
      if (rx_push && rx_fifo_full) rx_ovf_reg <= 1'b1;
      else if (rx_pop || rx_push) rx_ovf_reg <= 1'b0;
    end
  end

  // data entered rx
  // a push in the draining cycle wins, so no byte goes unflagged
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rx_req_reg <= 1'b0;
    end else if (pclken) begin
      if (rx_push) rx_req_reg <= 1'b1;
      else if (rx_fifo_empty) rx_req_reg <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // transfer complete, software clearable
  // ----------------------------------------------------------------
  // writing one to bit 8 of the status word, or dropping the enable
  assign done_clr = (stat_wr && ra.wdata[`ST_XFER_DONE])
                 || (ctrl_wr && !ra.wdata[`CT_COMPLETE_IE]);

  // clear by software
  // the set wins over a clear in the same cycle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      xfer_done_reg <= 1'b0;
    end else if (pclken) begin
      if (xfer_done_evt) xfer_done_reg <= 1'b1;
      else if (done_clr) xfer_done_reg <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // nack and arbitration flags
  // ----------------------------------------------------------------
  // these hold until the master starts its next transaction
  // data nack flag
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      data_nack_reg <= 1'b0;
    end else if (pclken) begin
      if (data_nack_evt) data_nack_reg <= 1'b1;
      else if (master_start) data_nack_reg <= 1'b0;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      addr_nack_reg <= 1'b0;
    end else if (pclken) begin
      if (addr_nack_evt) addr_nack_reg <= 1'b1;
      else if (master_start) addr_nack_reg <= 1'b0;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      arb_lost_reg <= 1'b0;
    end else if (pclken) begin
      if (arb_lost_evt) arb_lost_reg <= 1'b1;
      else if (master_start) arb_lost_reg <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // master activity
  // ----------------------------------------------------------------
  // busy while processing
  // low when bus lost
  // after a lost arbitration the other master owns the bus, so the
  // engine's busy is ignored until it starts afresh
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      master_act_reg <= 1'b0;
    end else if (pclken) begin
      master_act_reg <= master_busy && !arb_lost_evt
                     && (!arb_lost_reg || master_start);
    end
  end

  // ----------------------------------------------------------------
  // transmit side
  // ----------------------------------------------------------------
  // tx level code
  // a full fifo always shows 11 whatever the raw count says
  always_comb begin
    if (tx_fifo_full) tx_lvl_next = `TX_LVL_FULL;
    else tx_lvl_next = tx_count;
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tx_lvl_reg <= `TX_LVL_EMPTY;
      tx_req_reg <= 1'b0;
    end else if (pclken) begin
      tx_lvl_reg <= tx_lvl_next;
      tx_req_reg <= addr_write_sent && (tx_lvl_next <= `TX_REQ_MAX_BYTES);
    end
  end

  // ----------------------------------------------------------------
  // status word assembly
  // ----------------------------------------------------------------
  // read-only word
  always_comb begin
    status_word = `STAT_RESET;
    status_word[`ST_BUS_BUSY] = (bus_state_reg == BUS_HELD);
    status_word[`ST_RX_OVF] = rx_ovf_reg;
    status_word[`ST_XFER_DONE] = xfer_done_reg;
    status_word[`ST_DATA_NACK] = data_nack_reg;
    status_word[`ST_MASTER_ACT] = master_act_reg;
    status_word[`ST_ARB_LOST] = arb_lost_reg;
    status_word[`ST_ADDR_NACK] = addr_nack_reg;
    status_word[`ST_RX_REQ] = rx_req_reg;
    status_word[`ST_TX_REQ] = tx_req_reg;
    status_word[`ST_TX_LVL_HI:`ST_TX_LVL_LO] = tx_lvl_reg;
    status_word = status_word & `STAT_USED_MASK;
  end

  // read mux for the apb port
  always_comb begin
    if (addr_is(ra.addr, `CTRL_ADDR)) ra.rdata = control_reg;
    else if (addr_is(ra.addr, `STAT_ADDR)) ra.rdata = status_word;
    else ra.rdata = 16'h0000;
  end

  // ----------------------------------------------------------------
  // interrupt request
  // ----------------------------------------------------------------
  localparam int NSRC = 6;
  logic [NSRC-1:0] irq_src;
  logic [NSRC-1:0] irq_en;
  logic [NSRC-1:0] irq_gated;

  // both nack flags share one enable
  assign irq_src = {xfer_done_reg, data_nack_reg, addr_nack_reg,
                    arb_lost_reg, tx_req_reg, rx_req_reg};
  assign irq_en = {control_reg[`CT_COMPLETE_IE], control_reg[`CT_NACK_IE],
                   control_reg[`CT_NACK_IE], control_reg[`CT_ARB_IE],
                   control_reg[`CT_TX_IE], control_reg[`CT_RX_IE]};

  genvar gi;
  generate
    for (gi = 0; gi < NSRC; gi++) begin : g_irq
      assign irq_gated[gi] = irq_src[gi] & irq_en[gi];
    end
  endgenerate

  // level output built from flops, so it is glitch free
  assign irq = |irq_gated;

endmodule : i2c_master_status_flags

// file: common/i2c_status_defines.svh
// Purpose: offsets, field positions, reset values and counts for the
//          i2c master status block
// Assumes: included by bare name from design files
// Notes:   definitions only
`ifndef I2C_STATUS_DEFINES_SVH
`define I2C_STATUS_DEFINES_SVH

// ----------------------------------------------------------------
// register byte addresses
// ----------------------------------------------------------------
`define CTRL_ADDR 32'hffff0800
`define STAT_ADDR 32'hffff0804

// ----------------------------------------------------------------
// reset values and write masks
// ----------------------------------------------------------------
`define CTRL_RESET 16'h0000
`define STAT_RESET 16'h0000
`define CTRL_WR_MASK 16'h01f7
`define STAT_USED_MASK 16'h07ff

// ----------------------------------------------------------------
// status field positions
// ----------------------------------------------------------------
`define ST_BUS_BUSY 10
`define ST_RX_OVF 9
`define ST_XFER_DONE 8
`define ST_DATA_NACK 7
`define ST_MASTER_ACT 6
`define ST_ARB_LOST 5
`define ST_ADDR_NACK 4
`define ST_RX_REQ 3
`define ST_TX_REQ 2
`define ST_TX_LVL_HI 1
`define ST_TX_LVL_LO 0

// ----------------------------------------------------------------
// control field positions
// ----------------------------------------------------------------
`define CT_COMPLETE_IE 8
`define CT_NACK_IE 7
`define CT_ARB_IE 6
`define CT_TX_IE 5
`define CT_RX_IE 4

// ----------------------------------------------------------------
// tx fifo level codes and pin synchroniser depth
// ----------------------------------------------------------------
`define TX_LVL_EMPTY 2'h0
`define TX_LVL_FULL 2'h3
`define TX_REQ_MAX_BYTES 2'h1
`define SYNC_STAGES 3

`endif

// file: common/i2c_status_pkg.sv
// Purpose: shared types for the i2c master status block
// Assumes: nothing
// Notes:   numbers live in the defines header
package i2c_status_pkg;

  // one-hot view of who owns the i2c bus
  typedef enum logic [1:0] {
    BUS_FREE = 2'b01,
    BUS_HELD = 2'b10
  } bus_state_e;

  typedef logic [15:0] reg16_t;

  // exact word match of a bus address against a register address
  function automatic logic addr_is(input logic [31:0] a, input logic [31:0] r);
    addr_is = (a == r);
  endfunction : addr_is

endpackage : i2c_status_pkg

// file: common/line_event_if.sv
// Purpose: carries start and stop detections from the line watcher
// Assumes: one clock, pclk
// Notes:   both strobes are one-cycle pulses
`timescale 1ns/1ns
interface line_event_if;
  logic start_det;
  logic stop_det;
  modport src (output start_det, output stop_det);
  modport dst (input start_det, input stop_det);
endinterface : line_event_if

// file: common/reg_access_if.sv
// Purpose: register access strobes between apb port and status core
// Assumes: one clock, pclk
// Notes:   strobes are single-cycle, qualified by the clock enable
`timescale 1ns/1ns
interface reg_access_if;
  logic wr_stb;
  logic [31:0] addr;
  logic [15:0] wdata;
  logic [15:0] rdata;
  modport port (output wr_stb, output addr, output wdata, input rdata);
  modport core (input wr_stb, input addr, input wdata, output rdata);
endinterface : reg_access_if

// file: hw/i2c_line_watch.sv
// Purpose: synchronise scl/sda and detect start and stop conditions
// Assumes: pins are asynchronous to pclk
// Notes:   a level change counts once stages one and two agree
`timescale 1ns/1ns
`include "i2c_status_defines.svh"
module i2c_line_watch (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic pclken,
  input wire logic scl_pin,
  input wire logic sda_pin,
  line_event_if.src ev
);
  // ----------------------------------------------------------------
  // three-stage synchronisers, idle bus reads high
  // ----------------------------------------------------------------
  logic [`SYNC_STAGES-1:0] scl_sync_reg;
  logic [`SYNC_STAGES-1:0] sda_sync_reg;
  logic scl_reg;
  logic sda_reg;

  // shift chains; stage zero only feeds stage one
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      scl_sync_reg <= {`SYNC_STAGES{1'b1}};
      sda_sync_reg <= {`SYNC_STAGES{1'b1}};
    end else if (pclken) begin
      scl_sync_reg <= {scl_sync_reg[`SYNC_STAGES-2:0], scl_pin};
      sda_sync_reg <= {sda_sync_reg[`SYNC_STAGES-2:0], sda_pin};
    end
  end

  // accepted levels move only when stages one and two agree
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      scl_reg <= 1'b1;
      sda_reg <= 1'b1;
    end else if (pclken) begin
      if (scl_sync_reg[1] == scl_sync_reg[2]) scl_reg <= scl_sync_reg[2];
      if (sda_sync_reg[1] == sda_sync_reg[2]) sda_reg <= sda_sync_reg[2];
    end
  end

  // ----------------------------------------------------------------
  // conditions: sda moves while scl stays high
  // ----------------------------------------------------------------
  logic sda_new;
  logic scl_steady_hi;
  assign sda_new = (sda_sync_reg[1] == sda_sync_reg[2]) ? sda_sync_reg[2] : sda_reg;
  assign scl_steady_hi = scl_reg && (scl_sync_reg[2] || scl_sync_reg[1] != scl_sync_reg[2]);
  // qualified by the clock enable so a frozen block sees no pulse
  assign ev.start_det = pclken && scl_steady_hi && sda_reg && !sda_new;
  assign ev.stop_det = pclken && scl_steady_hi && !sda_reg && sda_new;
endmodule : i2c_line_watch

// file: hw/apb_reg_port.sv
// Purpose: apb slave front end for the status block registers
// Assumes: apb master keeps the request stable until pready
// Notes:   zero wait states while pclken is high
`timescale 1ns/1ns
`include "i2c_status_defines.svh"
module apb_reg_port (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic pclken,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  reg_access_if.port ra
);
  import i2c_status_pkg::*;

  logic mapped;
  logic [31:0] prdata_reg;

  // decode of the two words, everything else is an error
  always_comb begin
    if (addr_is(paddr, `CTRL_ADDR)) mapped = 1'b1;
    else if (addr_is(paddr, `STAT_ADDR)) mapped = 1'b1;
    else mapped = 1'b0;
  end

  // a frozen block stretches the access phase instead of losing it
  assign pready = pclken;
  assign pslverr = psel && penable && pclken && !mapped;
  assign ra.addr = paddr;
  assign ra.wdata = pwdata[15:0];
  assign ra.wr_stb = psel && penable && pwrite && pclken && mapped;
  assign prdata = prdata_reg;

  // read data caught in the setup cycle so it comes from a flop
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata_reg <= 32'h00000000;
    end else if (pclken && psel && !penable) begin
      prdata_reg <= (!pwrite && mapped) ? {16'h0000, ra.rdata} : 32'h00000000;
    end
  end
endmodule : apb_reg_port

// file: tb/i2c_line_model.sv
// Purpose: far side of the i2c pads, other masters making start and stop
// Assumes: open-drain lines with pull-ups, so idle reads high
// Notes:   scl stands high outside frames, nothing toggles in between
`timescale 1ns/1ns
module i2c_line_model (
  input wire logic pclk,
  output logic scl,
  output logic sda
);
  // released lines float up to the pull-up level
  initial begin
    scl = 1'b1;
    sda = 1'b1;
  end

  // slow steps, far above the three-flop sync delay
  task automatic gap();
    repeat (6) @(posedge pclk);
  endtask : gap

  // sda falls while scl is high, then the clock parks low
  task automatic start_cond();
    gap();
    sda <= 1'b0;
    gap();
    scl <= 1'b0;
    gap();
  endtask : start_cond

  // sda held low while scl is released, then sda rises with scl high
  task automatic stop_cond();
    sda <= 1'b0;
    gap();
    scl <= 1'b1;
    gap();
    sda <= 1'b1;
    gap();
  endtask : stop_cond
endmodule : i2c_line_model

// file: tb/status_flags_assertions.sv
// Purpose: port-level checks of flags, enables and interrupt
// Assumes: one clock, pclk; async active-low reset
// Notes:   bound to the top module, sees its ports only
`timescale 1ns/1ns
`include "i2c_status_defines.svh"
module status_flags_checker (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic pclken,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic xfer_done_evt,
  input wire logic addr_nack_evt,
  input wire logic data_nack_evt,
  input wire logic arb_lost_evt,
  input wire logic rx_push,
  input wire i2c_status_pkg::reg16_t master_control,
  input wire logic irq
);
  import i2c_status_pkg::*;
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  // ----------------------------------------------------------------
  // sequences
  // ----------------------------------------------------------------
  // no register access, so enables cannot move under the event
  sequence s_calm;
    pclken && !psel;
  endsequence
  sequence s_setup_st;
    psel && !penable && pclken && paddr == `STAT_ADDR;
  endsequence
  sequence s_ctrl_wr;
    psel && penable && pclken && pwrite && paddr == `CTRL_ADDR;
  endsequence
  // ----------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------
  a_done_irq: assert property (s_calm ##0 xfer_done_evt && master_control[8] |=> irq)
    else $error("done event did not raise irq");
  a_nack_irq: assert property (s_calm ##0 (addr_nack_evt || data_nack_evt)
    && master_control[7] |=> irq) else $error("nack event did not raise irq");
  a_arb_irq: assert property (s_calm ##0 arb_lost_evt && master_control[6] |=> irq)
    else $error("arbitration loss did not raise irq");
  a_rx_irq: assert property (s_calm ##0 rx_push && master_control[4] |=> irq)
    else $error("rx push did not raise irq");
  a_irq_quiet: assert property (master_control[8:4] == 5'h00 |-> !irq)
    else $error("irq high with all enables off");
  a_ctrl_mask: assert property ((master_control & ~`CTRL_WR_MASK) == 16'h0000)
    else $error("reserved control bit set");
  a_ctrl_write: assert property (s_ctrl_wr |=> {16'h0000, master_control}
    == ($past(pwdata) & {16'h0000, `CTRL_WR_MASK})) else $error("control write lost");
  a_stat_high: assert property (s_setup_st |=> prdata[31:11] == 21'h000000)
    else $error("status upper bits not zero");
endmodule : status_flags_checker

bind i2c_master_status_flags status_flags_checker chk (
  .pclk(pclk), .presetn(presetn), .pclken(pclken), .psel(psel), .penable(penable),
  .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
  .xfer_done_evt(xfer_done_evt), .addr_nack_evt(addr_nack_evt),
  .data_nack_evt(data_nack_evt), .arb_lost_evt(arb_lost_evt), .rx_push(rx_push),
  .master_control(master_control), .irq(irq)
);

// file: tb/i2c_master_status_flags_tb.sv
// Purpose: self-checking bench for the i2c master status block
// Assumes: apb master changes signals by nba after rising edges
// Notes:   engine and fifo reports are driven straight from the bench
`timescale 1ns/1ns
`include "i2c_status_defines.svh"
module i2c_master_status_flags_tb;
  import i2c_status_pkg::*;
  logic pclk, presetn, pclken, psel, penable, pwrite, err;
  logic [31:0] paddr, pwdata, prdata, rd;
  logic pready, pslverr, scl_pin, sda_pin, master_busy, addr_write_sent, irq;
  logic rx_fifo_full, rx_fifo_empty, tx_fifo_full;
  logic [1:0] tx_count;
  // event strobes: start, done, addr nack, data nack, arb, push, pop
  logic [6:0] ev;
  reg16_t master_control;
  int mismatches, tests_run, cycles;

  i2c_line_model line (.pclk(pclk), .scl(scl_pin), .sda(sda_pin));
  i2c_master_status_flags dut (
    .pclk(pclk), .presetn(presetn), .pclken(pclken), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .scl_pin(scl_pin), .sda_pin(sda_pin),
    .master_busy(master_busy), .master_start(ev[0]), .addr_write_sent(addr_write_sent),
    .xfer_done_evt(ev[1]), .addr_nack_evt(ev[2]), .data_nack_evt(ev[3]),
    .arb_lost_evt(ev[4]), .rx_push(ev[5]), .rx_pop(ev[6]), .rx_fifo_full(rx_fifo_full),
    .rx_fifo_empty(rx_fifo_empty), .tx_count(tx_count), .tx_fifo_full(tx_fifo_full),
    .master_control(master_control), .irq(irq)
  );

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  initial begin
    pclk = 1'b0;
    forever #4 pclk = ~pclk;
  end

  // a hang in any wait loop ends the run here
  always @(posedge pclk) begin
    cycles++;
    if (cycles == 20000) begin
      mismatches++;
      test_done();
    end
  end

  task test_done();
    $display("comparisons %0d mismatches %0d", tests_run, mismatches);
    if (mismatches == 0 && tests_run > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask : test_done

  task chk16(input string what, input logic [15:0] exp, input logic [15:0] got);
    tests_run++;
    if (got !== exp) begin
      mismatches++;
      $display("mismatch %s expected %h seen %h", what, exp, got);
    end
  endtask : chk16

  task chk1(input string what, input logic exp, input logic got);
    tests_run++;
    if (got !== exp) begin
      mismatches++;
      $display("mismatch %s expected %b seen %b", what, exp, got);
    end
  endtask : chk1

  // request held until pready is seen high at a rising edge
  task apb(input logic wr, input logic [31:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1) @(posedge pclk);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task ctl(input logic [15:0] d);
    apb(1'b1, `CTRL_ADDR, {16'h0000, d});
  endtask : ctl

  task st_is(input logic [15:0] exp);
    apb(1'b0, `STAT_ADDR, 32'h0);
    chk16("status", exp, rd[15:0]);
  endtask : st_is

  task idle(input int n);
    repeat (n) @(posedge pclk);
  endtask : idle

  // one-cycle strobe on an event line
  task pulse(input int i);
    @(posedge pclk);
    ev[i] <= 1'b1;
    @(posedge pclk);
    ev <= 7'h00;
  endtask : pulse

  // ----------------------------------------------------------------
  // scenarios
  // ----------------------------------------------------------------
  task t_regs();
    st_is(16'h0000);
    ctl(16'hffff);
    apb(1'b0, `CTRL_ADDR, 32'h0);
    chk16("control", 16'h01f7, rd[15:0]);
    ctl(16'h0000);
    apb(1'b1, `STAT_ADDR, 32'hffffffff);
    st_is(16'h0000);
    apb(1'b0, `STAT_ADDR + 32'h100, 32'h0);
    chk1("slverr", 1'b1, err);
    chk16("unmapped", 16'h0000, rd[15:0]);
    pclken <= 1'b0;
    pulse(1);
    chk1("pready", 1'b0, pready);
    pclken <= 1'b1;
    st_is(16'h0000);
  endtask : t_regs

  task t_bus();
    line.start_cond();
    idle(8);
    st_is(16'h0400);
    line.stop_cond();
    idle(8);
    st_is(16'h0000);
  endtask : t_bus

  task t_done();
    ctl(16'h0100);
    pulse(1);
    st_is(16'h0100);
    chk1("irq", 1'b1, irq);
    apb(1'b1, `STAT_ADDR, 32'h100);
    st_is(16'h0000);
    chk1("irq", 1'b0, irq);
    ctl(16'h0000);
    pulse(1);
    idle(1);
    chk1("irq", 1'b0, irq);
    st_is(16'h0100);
    ctl(16'h0000);
    st_is(16'h0000);
  endtask : t_done

  task t_nack();
    ctl(16'h0080);
    pulse(2);
    st_is(16'h0010);
    chk1("irq", 1'b1, irq);
    pulse(0);
    st_is(16'h0000);
    pulse(3);
    st_is(16'h0080);
    chk1("irq", 1'b1, irq);
    pulse(0);
    st_is(16'h0000);
  endtask : t_nack

  task t_arb();
    master_busy <= 1'b1;
    idle(2);
    st_is(16'h0040);
    ctl(16'h0040);
    pulse(4);
    st_is(16'h0020);
    chk1("irq", 1'b1, irq);
    master_busy <= 1'b0;
    pulse(0);
    st_is(16'h0000);
  endtask : t_arb

  task t_rx();
    ctl(16'h0010);
    rx_fifo_empty <= 1'b0;
    pulse(5);
    st_is(16'h0008);
    chk1("irq", 1'b1, irq);
    rx_fifo_full <= 1'b1;
    pulse(5);
    st_is(16'h0208);
    rx_fifo_full <= 1'b0;
    pulse(6);
    st_is(16'h0008);
    rx_fifo_empty <= 1'b1;
    idle(2);
    st_is(16'h0000);
    chk1("irq", 1'b0, irq);
  endtask : t_rx

  // fill levels empty, one, two and full with address+write sent
  task t_tx();
    logic [1:0] lvl;
    ctl(16'h0020);
    addr_write_sent <= 1'b1;
    for (int i = 0; i < 4; i++) begin
      tx_count <= (i == 3) ? 2'h2 : 2'(i);
      tx_fifo_full <= (i == 3);
      idle(3);
      lvl = 2'(i);
      st_is({13'h0000, lvl <= 2'h1, lvl});
      chk1("irq", lvl <= 2'h1, irq);
    end
    addr_write_sent <= 1'b0;
    tx_count <= 2'h0;
    tx_fifo_full <= 1'b0;
    idle(3);
    st_is(16'h0000);
  endtask : t_tx

  // every input has a value at time zero, reset held four cycles
  initial begin
    {presetn, psel, penable, pwrite, master_busy, addr_write_sent} = 6'h00;
    {rx_fifo_full, tx_fifo_full, ev, tx_count, paddr, pwdata} = '0;
    {pclken, rx_fifo_empty} = 2'h3;
    cycles = 0;
    repeat (4) @(posedge pclk);
    presetn <= 1'b1;
    t_regs();
    t_bus();
    t_done();
    t_nack();
    t_arb();
    t_rx();
    t_tx();
    test_done();
  end
endmodule : i2c_master_status_flags_tb
